// file: dv/swr_host.sv
// Host model: start pulse, then decodes the 40-bit reply.
// Assumes a pulled-up line that reads low while either side drives.
`timescale 1ns/100ps
module swr_host #(
  parameter int START_CYC = 360_000,    // Start low, 18 ms at 20 MHz
  parameter int INIT_CYC  = 20_000_000  // Power-up wait, 1 s at 20 MHz
) (
  input  wire logic        clock_i,
  input  wire logic        line_i,
  input  wire logic        start_i,
  output logic             host_oe_o,
  output logic [39:0]      frame_o,
  output logic             frame_vld_o
);
  int n;
  int hi;
  int w;
  // One read per start request
  initial begin
    host_oe_o = 1'b0;
    frame_vld_o = 1'b0;
    frame_o = '0;
    repeat (INIT_CYC) @(posedge clock_i);
    forever begin
      @(posedge clock_i iff start_i);
      #1 host_oe_o = 1'b1;
      repeat (START_CYC) @(posedge clock_i);
      #1 host_oe_o = 1'b0;
      n = 0;
      hi = 0;
      w = 0;
      while (n < 42 && w < 90000) begin
        @(negedge clock_i);
        w++;
        if (line_i) hi++;
        else if (hi > 0) begin
          if (n > 1) frame_o = {frame_o[38:0], hi > 1000};
          n++;
          hi = 0;
        end
      end
      // Frames with a bad checksum are dropped, as a real host would
      frame_vld_o = (n == 42) &&
        (frame_o[7:0] == 8'(frame_o[39:32] + frame_o[31:24] + frame_o[23:16] + frame_o[15:8]));
      @(posedge clock_i);
      #1 frame_vld_o = 1'b0;
    end
  end
endmodule

// file: dv/swr_sensor_properties.sv
// Timing checker for the sensor link, bound to swr_sensor.
// Assumes line_i follows line_oe_o on the same cycle.
`timescale 1ns/100ps
module swr_sensor_chk (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic line_i,
  input wire logic line_o,
  input wire logic line_oe_o,
  input wire logic busy_o,
  input wire logic done_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  logic [11:0] drv_r;
  logic [11:0] rel_r;
  logic [5:0]  fall_r;
  logic        oe_q_r;
  // Run lengths of driven and released line, falls per transfer
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      drv_r  <= 12'h000;
      rel_r  <= 12'h000;
      fall_r <= 6'h00;
      oe_q_r <= 1'b0;
    end else begin
      drv_r  <= line_oe_o ? drv_r + 12'h001 : 12'h000;
      rel_r  <= (line_oe_o || !line_i) ? 12'h000 : rel_r + 12'h001;
      fall_r <= !busy_o ? 6'h00 : fall_r + 6'(oe_q_r && !line_oe_o);
      oe_q_r <= line_oe_o;
    end
  end
  property p_od; line_o == 1'b0; endproperty
  a_od: assert property (p_od) else $error("line output not low");
  property p_idle; !busy_o |-> !line_oe_o; endproperty
  a_idle: assert property (p_idle) else $error("drive while idle");
  property p_resp; $rose(line_oe_o) && fall_r == 6'h00 |-> rel_r inside {[12'h258:12'h25a]}; endproperty
  a_resp: assert property (p_resp) else $error("reply pause");
  property p_ack_lo; $fell(line_oe_o) && fall_r == 6'h00 |-> drv_r == 12'h640; endproperty
  a_ack_lo: assert property (p_ack_lo) else $error("ack low length");
  property p_ack_hi; $rose(line_oe_o) && fall_r == 6'h01 |-> rel_r == 12'h640; endproperty
  a_ack_hi: assert property (p_ack_hi) else $error("ack high length");
  property p_bit_lo; $fell(line_oe_o) && fall_r != 6'h00 |-> drv_r == 12'h3e8; endproperty
  a_bit_lo: assert property (p_bit_lo) else $error("low length");
  property p_bit_hi; $rose(line_oe_o) && fall_r > 6'h01 |-> rel_r inside {12'h21c, 12'h578}; endproperty
  a_bit_hi: assert property (p_bit_hi) else $error("bit high length");
  property p_count; $fell(busy_o) |-> fall_r == 6'h2a; endproperty
  a_count: assert property (p_count) else $error("bit count");
  property p_done; done_o |=> !done_o ##1 !busy_o; endproperty
  a_done: assert property (p_done) else $error("done pulse");
endmodule
bind swr_sensor swr_sensor_chk u_swr_sensor_chk (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
  .line_i(line_i), .line_o(line_o), .line_oe_o(line_oe_o), .busy_o(busy_o), .done_o(done_o));

// file: dv/tb.sv
// Testbench: FIFO fill and refusal, two reads checked by a scoreboard.
// Assumes the host model and checker are compiled alongside.
`timescale 1ns/100ps
module tb;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic meas_valid_i = 1'b0;
  logic start = 1'b0;
  swr_pkg::swr_meas_t meas_i = '0;
  logic line_o, line_oe_o, meas_ready_o, busy_o, done_o, host_oe, vld;
  logic [39:0] frame;
  logic [39:0] exp_q[$];
  logic [31:0] word0;
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  wire line = !(line_oe_o || host_oe);
  swr_sensor #(.FIFO_DEPTH(4)) u_swr_sensor (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .line_i(line), .line_o(line_o), .line_oe_o(line_oe_o), .meas_i(meas_i),
    .meas_valid_i(meas_valid_i), .meas_ready_o(meas_ready_o), .busy_o(busy_o),
    .done_o(done_o));
  // Start low and power-up wait cut short: the sensor times neither
  swr_host #(.START_CYC(200), .INIT_CYC(4)) u_swr_host (.clock_i(clock_i), .line_i(line),
    .start_i(start),
    .host_oe_o(host_oe), .frame_o(frame), .frame_vld_o(vld));
  initial begin
    forever #25 clock_i = !clock_i;
  end
  task automatic wrap_up;
    if (n_fail == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk_f(input logic [39:0] e, input logic [39:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: frame %h want %h", $time, g, e);
    end
  endtask
  task automatic chk_b(input logic g, input logic e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: flag %b want %b", $time, g, e);
    end
  endtask
  function automatic logic [39:0] fr(input logic [31:0] m);
    return {m, m[31:24] + m[23:16] + m[15:8] + m[7:0]};
  endfunction
  // One read: note the frame, start, wait for the end
  task automatic rd(input logic [39:0] e);
    int k;
    exp_q.push_back(e);
    @(posedge clock_i);
    #1 start = 1'b1;
    @(posedge clock_i);
    #1 start = 1'b0;
    for (k = 0; k < 90000 && done_o !== 1'b1; k++) @(negedge clock_i);
    chk_b(done_o, 1'b1);
    repeat (3) @(negedge clock_i);
    chk_b(done_o, 1'b0);
    chk_b(busy_o, 1'b0);
  endtask
  // Scoreboard on decoded frames
  always @(posedge clock_i) begin
    if (vld === 1'b1) chk_f(exp_q.pop_front(), frame);
  end
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 160000) begin
      n_fail++;
      wrap_up();
    end
  end
  initial begin
    void'($urandom(32'h0db0));
    repeat (2) @(posedge clock_i);
    #1 sys_rst_i = 1'b0;
    for (int i = 0; i < 5; i++) begin
      @(posedge clock_i);
      #1 meas_i = $urandom & 32'h0103_0107;
      meas_valid_i = 1'b1;
      if (i == 0) word0 = meas_i;
    end
    @(posedge clock_i);
    #1 meas_valid_i = 1'b0;
    repeat (2) @(posedge clock_i);
    #1;
    chk_b(meas_ready_o, 1'b0);
    rd(fr(32'h0000_0000));
    rd(fr(word0));
    chk_b(meas_ready_o, 1'b1);
    chk_b(exp_q.size() == 0, 1'b1);
    wrap_up();
  end
endmodule

// file: rtl/swr_pkg.sv
// Package for the single-wire sensor readout block: timing, states, carriers.
// Assumes a 20 MHz system clock and one open-drain line with external pull-up.
package swr_pkg;

  // ----------------------------------------------------------------------
  // Clock and line timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ        = 20_000_000;
  localparam int CYC_PER_US    = CLK_HZ / 1_000_000;
  localparam int RESP_DLY_US   = 30;   // Pause after host releases line
  localparam int ACK_LO_US     = 80;
  localparam int ACK_HI_US     = 80;
  localparam int BIT_LO_US     = 50;
  localparam int ZERO_HI_US    = 27;   // Inside the 26 to 28 us window
  localparam int ONE_HI_US     = 70;
  localparam int END_LO_US     = 50;
  localparam int RESP_DLY_CYC  = RESP_DLY_US * CYC_PER_US;
  localparam int ACK_LO_CYC    = ACK_LO_US * CYC_PER_US;
  localparam int ACK_HI_CYC    = ACK_HI_US * CYC_PER_US;
  localparam int BIT_LO_CYC    = BIT_LO_US * CYC_PER_US;
  localparam int ZERO_HI_CYC   = ZERO_HI_US * CYC_PER_US;
  localparam int ONE_HI_CYC    = ONE_HI_US * CYC_PER_US;
  localparam int END_LO_CYC    = END_LO_US * CYC_PER_US;
  localparam int CNT_W         = 11;
  localparam int FRAME_BITS    = 40;
  localparam int BITN_W        = 6;
  localparam int FIFO_DEPTH    = 4;

  // Reset values
  localparam logic [31:0] MEAS_RST = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Carriers and states
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] hum_int;
    logic [7:0] hum_frac;
    logic [7:0] temp_int;
    logic [7:0] temp_frac;
  } swr_meas_t;

  typedef enum logic [8:0] {
    ST_IDLE   = 9'h001,
    ST_WAIT_H = 9'h002,
    ST_DELAY  = 9'h004,
    ST_ACK_LO = 9'h008,
    ST_ACK_HI = 9'h010,
    ST_BIT_LO = 9'h020,
    ST_BIT_HI = 9'h040,
    ST_END_LO = 9'h080,
    ST_LOAD   = 9'h100
  } swr_state_t;

endpackage

// file: rtl/swr_sensor.sv
// Sensor end of a single-wire readout link, plus its measurement FIFO.
// Assumes the line input is synchronous to clock_i and the pull-up idles it high.
// Notes on behaviour
// - Idle pin released; watch host low, await its end, pause, then drive.
// - Acknowledge by driving the line low for 80 us.
// - Then release line high for 80 us before data.
// - Exactly 40 data bits follow the acknowledge.
// - Zero bit: 50 us low, then 26 to 28 us high.
// - One bit: 50 us low, then 70 us high.
// - After last bit, 50 us low, then release the line.
// - After each transfer take a new measurement if the FIFO holds one (else keep the old), then idle again.
// - Send MSB first: hum int, hum frac, temp int, temp frac, checksum.
`timescale 1ns/100ps

// --------------------------------------------------------------------------
// Measurement FIFO
// --------------------------------------------------------------------------
module swr_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = swr_pkg::FIFO_DEPTH
) (
  input  wire logic             clock_i,
  input  wire logic             sys_rst_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Refuse shapes the pointer logic cannot serve
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_chk
    $error("swr_fifo: DEPTH must be a power of two >= 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
    logic                        full;
  } swr_fifo_st_t;

  swr_fifo_st_t st_r;
  swr_fifo_st_t st_nxt;
  logic         push;
  logic         pop;

  assign push        = in_valid_i && !st_r.full;
  assign pop         = out_ready_i && (st_r.cnt != '0);
  assign in_ready_o  = !st_r.full;
  assign out_valid_o = (st_r.cnt != '0);
  assign out_data_o  = st_r.mem[st_r.rp];

  // Pointer and count update
  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wp] = in_data_i;
      st_nxt.wp           = st_r.wp + 1'b1;
    end
    if (pop) begin
      st_nxt.rp = st_r.rp + 1'b1;
    end
    if (push && !pop) begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end else if (pop && !push) begin
      st_nxt.cnt = st_r.cnt - 1'b1;
    end
    st_nxt.full = (st_nxt.cnt == (AW + 1)'(DEPTH));
  end

  // State register
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

// --------------------------------------------------------------------------
// Sensor link engine
// --------------------------------------------------------------------------
module swr_sensor #(
  parameter int FIFO_DEPTH = swr_pkg::FIFO_DEPTH
) (
  input  wire logic              clock_i,
  input  wire logic              sys_rst_i,
  input  wire logic              line_i,
  output logic                   line_o,
  output logic                   line_oe_o,
  input  wire swr_pkg::swr_meas_t meas_i,
  input  wire logic              meas_valid_i,
  output logic                   meas_ready_o,
  output logic                   busy_o,
  output logic                   done_o
);
  typedef struct packed {
    swr_pkg::swr_state_t          state;
    logic [swr_pkg::CNT_W-1:0]    cnt;
    logic [swr_pkg::BITN_W-1:0]   bitn;
    logic [swr_pkg::FRAME_BITS-1:0] shift;
    swr_pkg::swr_meas_t           held;
    logic                         oe;
    logic                         busy;
    logic                         done;
    logic                         in_rdy;
  } swr_top_st_t;

  swr_top_st_t        st_r;
  swr_top_st_t        st_nxt;
  swr_pkg::swr_meas_t f_data;
  logic               f_valid;
  logic               f_ready;
  logic               f_in_ready;

  // Cycle count to load for a phase
  function automatic logic [swr_pkg::CNT_W-1:0] ld(input int cyc);
    ld = swr_pkg::CNT_W'(cyc - 1);
  endfunction

  // Checksum over the four data bytes
  function automatic logic [7:0] csum(input swr_pkg::swr_meas_t m);
    csum = 8'(m.hum_int + m.hum_frac + m.temp_int + m.temp_frac);
  endfunction

  // True when a phase of cyc clocks loads into the phase counter
  function automatic bit fits(input int cyc);
    fits = (cyc >= 1) && (cyc <= (1 << swr_pkg::CNT_W));
  endfunction

  // ------------------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------------------
  // Every phase must load into the phase counter, none may be empty
  if (!fits(swr_pkg::RESP_DLY_CYC) || !fits(swr_pkg::ACK_LO_CYC) ||
      !fits(swr_pkg::ACK_HI_CYC) || !fits(swr_pkg::BIT_LO_CYC) ||
      !fits(swr_pkg::ZERO_HI_CYC) || !fits(swr_pkg::ONE_HI_CYC) ||
      !fits(swr_pkg::END_LO_CYC)) begin : g_cnt_chk
    $error("swr_sensor: phase length does not fit the phase counter");
  end
  // Bit counter must reach the last bit of the frame
  if (swr_pkg::FRAME_BITS < 1 ||
      swr_pkg::FRAME_BITS > (1 << swr_pkg::BITN_W)) begin : g_bitn_chk
    $error("swr_sensor: bit counter too narrow for the frame");
  end
  // FIFO pointers need a power-of-two depth of at least two
  if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_depth_chk
    $error("swr_sensor: FIFO_DEPTH must be a power of two >= 2");
  end

  swr_fifo #(
    .WIDTH ($bits(swr_pkg::swr_meas_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock_i     (clock_i),
    .sys_rst_i   (sys_rst_i),
    .in_data_i   (meas_i),
    .in_valid_i  (meas_valid_i),
    .in_ready_o  (f_in_ready),
    .out_data_o  (f_data),
    .out_valid_o (f_valid),
    .out_ready_i (f_ready)
  );

  // FIFO drained only at the end-of-transfer load
  assign f_ready      = (st_r.state == swr_pkg::ST_LOAD);
  assign line_o       = 1'b0;
  assign line_oe_o    = st_r.oe;
  assign busy_o       = st_r.busy;
  assign done_o       = st_r.done;
  assign meas_ready_o = st_r.in_rdy;

  // Link sequencer
  always_comb begin
    st_nxt        = st_r;
    st_nxt.done   = 1'b0;
    st_nxt.in_rdy = f_in_ready;
    case (st_r.state)
      // Idle: pin released, any host low opens a transfer
      swr_pkg::ST_IDLE: begin
        st_nxt.oe   = 1'b0;
        st_nxt.busy = 1'b0;
        if (!line_i) begin
          st_nxt.state = swr_pkg::ST_WAIT_H;
          st_nxt.busy  = 1'b1;
        end
      end
      // Wait for the host to release the line
      swr_pkg::ST_WAIT_H: begin
        if (line_i) begin
          st_nxt.state = swr_pkg::ST_DELAY;
          st_nxt.cnt   = ld(swr_pkg::RESP_DLY_CYC);
        end
      end
      // Reply pause, then load the frame and pull low
      swr_pkg::ST_DELAY: begin
        if (st_r.cnt == '0) begin
          st_nxt.state = swr_pkg::ST_ACK_LO;
          st_nxt.cnt   = ld(swr_pkg::ACK_LO_CYC);
          st_nxt.oe    = 1'b1;
          st_nxt.shift = {st_r.held, csum(st_r.held)};
        end else begin
          st_nxt.cnt = st_r.cnt - 1'b1;
        end
      end
      // Acknowledge low, then release for the high half
      swr_pkg::ST_ACK_LO: begin
        if (st_r.cnt == '0) begin
          st_nxt.state = swr_pkg::ST_ACK_HI;
          st_nxt.cnt   = ld(swr_pkg::ACK_HI_CYC);
          st_nxt.oe    = 1'b0;
        end else begin
          st_nxt.cnt = st_r.cnt - 1'b1;
        end
      end
      // Acknowledge high, then first bit low
      swr_pkg::ST_ACK_HI: begin
        if (st_r.cnt == '0) begin
          st_nxt.state = swr_pkg::ST_BIT_LO;
          st_nxt.cnt   = ld(swr_pkg::BIT_LO_CYC);
          st_nxt.bitn  = '0;
          st_nxt.oe    = 1'b1;
        end else begin
          st_nxt.cnt = st_r.cnt - 1'b1;
        end
      end
      // Bit low, then high length picked from the current bit
      swr_pkg::ST_BIT_LO: begin
        if (st_r.cnt == '0) begin
          st_nxt.state = swr_pkg::ST_BIT_HI;
          st_nxt.oe    = 1'b0;
          if (st_r.shift[swr_pkg::FRAME_BITS-1]) begin
            st_nxt.cnt = ld(swr_pkg::ONE_HI_CYC);
          end else begin
            st_nxt.cnt = ld(swr_pkg::ZERO_HI_CYC);
          end
        end else begin
          st_nxt.cnt = st_r.cnt - 1'b1;
        end
      end
      // Bit high, then next bit low or the end low
      swr_pkg::ST_BIT_HI: begin
        if (st_r.cnt == '0) begin
          st_nxt.shift = {st_r.shift[swr_pkg::FRAME_BITS-2:0], 1'b0};
          st_nxt.bitn  = st_r.bitn + 1'b1;
          st_nxt.oe    = 1'b1;
          if (st_r.bitn == swr_pkg::BITN_W'(swr_pkg::FRAME_BITS - 1)) begin
            st_nxt.state = swr_pkg::ST_END_LO;
            st_nxt.cnt   = ld(swr_pkg::END_LO_CYC);
          end else begin
            st_nxt.state = swr_pkg::ST_BIT_LO;
            st_nxt.cnt   = ld(swr_pkg::BIT_LO_CYC);
          end
        end else begin
          st_nxt.cnt = st_r.cnt - 1'b1;
        end
      end
      // End low, then release the line for good
      swr_pkg::ST_END_LO: begin
        if (st_r.cnt == '0) begin
          st_nxt.state = swr_pkg::ST_LOAD;
          st_nxt.oe    = 1'b0;
        end else begin
          st_nxt.cnt = st_r.cnt - 1'b1;
        end
      end
      // Report the end and take the next measurement
      swr_pkg::ST_LOAD: begin
        // Fresh measurement for next read, old one kept if none waits
        if (f_valid) begin
          st_nxt.held = f_data;
        end
        st_nxt.done  = 1'b1;
        st_nxt.busy  = 1'b0;
        st_nxt.state = swr_pkg::ST_IDLE;
      end
      // Unused codes fall back to idle with the pin released
      default: begin
        st_nxt.state = swr_pkg::ST_IDLE;
        st_nxt.oe    = 1'b0;
      end
    endcase
  end

  // State register
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      st_r       <= '0;
      st_r.state <= swr_pkg::ST_IDLE;
      st_r.held  <= swr_pkg::MEAS_RST;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule
